// [rtl/tsico_pkg.sv]
// Shared constants and types of the slot-interchange configuration block
package tsico_pkg;
	// ****************
	// Sizes
	// ****************
	localparam int MAXS = 32;
	localparam int NOFS = 8;
	localparam int BUF_DEPTH = 2;
	localparam int BUF_W = 22;
	// ****************
	// Register addresses
	// ****************
	localparam logic [14:0] A_CTRL = 15'h0000;
	localparam logic [14:0] A_OFS0 = 15'h0001;
	localparam logic [14:0] A_OFS7 = 15'h0008;
	localparam logic [14:0] A_FAR = 15'h0009;
	localparam logic [14:0] A_EVSEL = 15'h000A;
	localparam int A_CONN_BIT = 14;
	// ****************
	// Field positions and reset values
	// ****************
	localparam int CTL_EVAL_BIT = 4;
	localparam int CW_MODE_LSB = 14;
	localparam int CW_STR_LSB = 8;
	localparam int OFS_GRP_W = 4;
	localparam int FAR_DONE_BIT = 15;
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam logic [15:0] OFS_RST = 16'h0000;
	localparam logic [15:0] FAR_RST = 16'h0000;
	localparam logic [4:0] EVSEL_RST = 5'h00;
	// ****************
	// Types
	// ****************
	typedef enum logic [1:0] {RATE_2M = 2'h0, RATE_4M = 2'h1, RATE_8M = 2'h2, RATE_16M = 2'h3} tsico_rate_t;
	typedef enum logic [1:0] {MODE_VAR = 2'h0, MODE_CONST = 2'h1, MODE_PROC = 2'h2, MODE_HIZ = 2'h3} tsico_mode_t;
	typedef enum logic [1:0] {F_IDLE = 2'b01, F_RUN = 2'b10} tsico_fetch_t;
	typedef enum logic [2:0] {E_IDLE = 3'b001, E_WAIT = 3'b010, E_COUNT = 3'b100} tsico_eval_t;
endpackage

// [rtl/tsico_buf_if.sv]
// Handshake carrier between the receive arbiter and the word buffer
`timescale 1ns/1ps
interface tsico_buf_if #(parameter int W = 22);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport buffer (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// [rtl/tsico_buf.sv]
// Small valid/ready word buffer
`timescale 1ns/1ps
module tsico_buf #(
	parameter int W = 22,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Buffer ports
	tsico_buf_if.buffer b
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
			$error("tsico_buf: DEPTH must be a power of two, at least 2");
		end
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [PW:0] cnt_q;
	wire push = b.in_valid && b.in_ready;
	wire pop = b.out_valid && b.out_ready;

	assign b.in_ready = cnt_q != (PW+1)'(DEPTH);
	assign b.out_valid = cnt_q != '0;
	assign b.out_data = mem[rp_q];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= b.in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= push ? wp_q + 1'b1 : wp_q;
			rp_q <= pop ? rp_q + 1'b1 : rp_q;
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // tsico_buf

// [rtl/tsico_top.sv]
// Slot-interchange switch core: rate, offsets, connection memory, frame evaluation
`timescale 1ns/1ps
module tsico_top import tsico_pkg::*; #(
	parameter int NS = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [14:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Serial link
	input wire logic link_clk,
	input wire logic frame_pulse_in,
	input wire logic [NS-1:0] rx_in,
	output logic [NS-1:0] tx_out,
	output logic [NS-1:0] tx_oe
);
	generate
		if (NS < 1 || NS > MAXS) begin : g_bad
			$error("tsico_top: NS must lie in 1..32");
		end
	endgenerate

	function automatic logic [7:0] chan_last(input logic [1:0] r);
		unique case (r)
			RATE_2M: chan_last = 8'h1F;
			RATE_4M: chan_last = 8'h3F;
			RATE_8M: chan_last = 8'h7F;
			default: chan_last = 8'hFF;
		endcase
	endfunction

	// ****************
	// Synchronisers
	// ****************
	logic lk_s1_q, lk_s2_q, lk_s3_q;
	logic fp_s1_q, fp_s2_q, fp_s3_q;
	logic [NS-1:0] rx_s1_q, rx_s2_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{lk_s1_q, lk_s2_q, lk_s3_q} <= 3'h0;
			{fp_s1_q, fp_s2_q, fp_s3_q} <= 3'h0;
			rx_s1_q <= '0;
			rx_s2_q <= '0;
		end else begin
			{lk_s1_q, lk_s2_q, lk_s3_q} <= {link_clk, lk_s1_q, lk_s2_q};
			{fp_s1_q, fp_s2_q, fp_s3_q} <= {frame_pulse_in, fp_s1_q, fp_s2_q};
			rx_s1_q <= rx_in;
			rx_s2_q <= rx_s1_q;
		end
	end

	// Both link edges count: half periods give the half-cycle resolution
	wire lk_edge = lk_s2_q ^ lk_s3_q;
	wire fstart = fp_s2_q && !fp_s3_q;
	wire [MAXS-1:0] rx_all = MAXS'(rx_s2_q);

	// ****************
	// Register port
	// ****************
	logic [1:0] rate_q;
	logic eval_q;
	logic [4:0] evsel_q;
	logic [15:0] ofs_q [NOFS];
	logic [15:0] far_q;
	logic [15:0] rdata_q;
	logic [15:0] conn_mem [MAXS*256];

	wire a_ctrl = reg_addr == A_CTRL;
	wire a_ofs = reg_addr >= A_OFS0 && reg_addr <= A_OFS7;
	wire a_far = reg_addr == A_FAR;
	wire a_evsel = reg_addr == A_EVSEL;
	wire a_conn = reg_addr[A_CONN_BIT];
	wire [14:0] ofs_off = reg_addr - A_OFS0;
	wire [2:0] ofs_i = ofs_off[2:0];
	wire [12:0] conn_i = reg_addr[12:0];
	wire [15:0] rd_ctrl = (16'(eval_q) << CTL_EVAL_BIT) | 16'(rate_q);
	wire [15:0] rd_d = a_conn ? conn_mem[conn_i] :
		a_ctrl ? rd_ctrl :
		a_ofs ? ofs_q[ofs_i] :
		a_far ? far_q :
		a_evsel ? 16'(evsel_q) : 16'h0000;
	wire eval_start = reg_wr && a_ctrl && reg_wdata[CTL_EVAL_BIT] && !eval_q;

	always_ff @(posedge clk) begin
		if (reg_wr && a_conn) begin
			conn_mem[conn_i] <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rate_q <= RATE_RST;
			eval_q <= 1'b0;
			evsel_q <= EVSEL_RST;
			rdata_q <= 16'h0000;
			for (int i = 0; i < NOFS; i++) begin
				ofs_q[i] <= OFS_RST;
			end
		end else begin
			rdata_q <= reg_rd ? rd_d : rdata_q;
			if (reg_wr && a_ctrl) begin
				rate_q <= reg_wdata[1:0];
				eval_q <= reg_wdata[CTL_EVAL_BIT];
			end
			if (reg_wr && a_evsel) begin
				evsel_q <= reg_wdata[4:0];
			end
			if (reg_wr && a_ofs) begin
				ofs_q[ofs_i] <= reg_wdata;
			end
		end
	end

	assign reg_rdata = rdata_q;

	// ****************
	// Frame timing
	// ****************
	logic [14:0] hp_q;
	logic wbank_q;
	// Rate 3 runs one master clock per bit, the others two
	wire sh2 = rate_q != RATE_16M;
	wire [7:0] ch_last = chan_last(rate_q);
	// Frame length in half periods; offset tails of the last channel spill past the pulse
	wire [14:0] flen = sh2 ? {2'h0, ch_last, 5'h00} + 15'h0020 : {3'h0, ch_last, 4'h0} + 15'h0010;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hp_q <= 15'h7FFF;
			wbank_q <= 1'b0;
		end else if (fstart) begin
			hp_q <= 15'h0000;
			wbank_q <= !wbank_q;
		end else if (lk_edge && hp_q != 15'h7FFF) begin
			hp_q <= hp_q + 15'h0001;
		end
	end

	// Output side runs with no offset
	wire [1:0] g_ph = sh2 ? hp_q[1:0] : {1'b0, hp_q[0]};
	wire [2:0] g_bp = sh2 ? hp_q[4:2] : hp_q[3:1];
	wire [7:0] g_ch = sh2 ? hp_q[12:5] : hp_q[11:4];
	wire g_top = sh2 ? hp_q[14:13] == 2'h0 : hp_q[14:12] == 3'h0;
	wire g_in = g_top && g_ch <= ch_last;
	wire g_bit = lk_edge && g_in && g_ph == 2'h0;
	wire g_chan = g_bit && g_bp == 3'h0;

	// ****************
	// Receivers
	// ****************
	logic [NS-1:0] pend;
	logic [NS-1:0] grant;
	logic [NS-1:0][7:0] pbyte;
	logic [NS-1:0][7:0] pchan;
	logic [NS-1:0] pbank;

	for (genvar s = 0; s < NS; s++) begin : g_rx
		logic [7:0] sr_q, pb_q, pc_q;
		logic pend_q, pk_q;
		wire [3:0] dly = ofs_q[s / 4][(s % 4) * OFS_GRP_W +: OFS_GRP_W];
		// Group value is offset*2 + half bit, i.e. half periods up to 15
		wire go = hp_q >= 15'(dly);
		// Until the offset runs out, the last channel of the old frame is still arriving
		wire [14:0] p = go ? hp_q - 15'(dly) : hp_q + flen - 15'(dly);
		wire [1:0] ph = sh2 ? p[1:0] : {1'b0, p[0]};
		wire [2:0] bp = sh2 ? p[4:2] : p[3:1];
		wire [7:0] ch = sh2 ? p[12:5] : p[11:4];
		wire top = sh2 ? p[14:13] == 2'h0 : p[14:12] == 3'h0;
		wire smp = lk_edge && top && ch <= ch_last && ph == (sh2 ? 2'h2 : 2'h1);
		wire done = smp && bp == 3'h7;

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				sr_q <= 8'h00;
				pb_q <= 8'h00;
				pc_q <= 8'h00;
				pend_q <= 1'b0;
				pk_q <= 1'b0;
			end else begin
				sr_q <= smp ? {sr_q[6:0], rx_s2_q[s]} : sr_q;
				pb_q <= done ? {sr_q[6:0], rx_s2_q[s]} : pb_q;
				pc_q <= done ? ch : pc_q;
				// A tail byte belongs to the bank of the frame it came in
				pk_q <= done ? (go ? wbank_q : !wbank_q) : pk_q;
				// A new byte beats the grant that takes the old one
				pend_q <= done ? 1'b1 : (grant[s] ? 1'b0 : pend_q);
			end
		end

		assign pend[s] = pend_q;
		assign pbyte[s] = pb_q;
		assign pchan[s] = pc_q;
		assign pbank[s] = pk_q;
	end

	// ****************
	// Arbiter and buffer
	// ****************
	function automatic logic [4:0] first_one(input logic [NS-1:0] v);
		first_one = 5'h00;
		for (int i = NS - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_one = 5'(i);
			end
		end
	endfunction

	tsico_buf_if #(.W(BUF_W)) bif ();
	logic [7:0] data_mem [2*MAXS*256];
	logic s1_v_q;

	wire [4:0] g_idx = first_one(pend);
	assign bif.in_valid = |pend;
	assign bif.in_data = {pbank[g_idx], g_idx, pchan[g_idx], pbyte[g_idx]};
	assign grant = (bif.in_ready && |pend) ? NS'(1) << g_idx : '0;
	// Fetch reads own the memory; buffered writes wait meanwhile
	assign bif.out_ready = !s1_v_q;
	wire dm_wr = bif.out_valid && bif.out_ready;

	tsico_buf #(.W(BUF_W), .DEPTH(BUF_DEPTH)) u_buf (
		.clk(clk),
		.rstn(rstn),
		.b(bif.buffer)
	);

	always_ff @(posedge clk) begin
		if (dm_wr) begin
			data_mem[bif.out_data[21:8]] <= bif.out_data[7:0];
		end
	end

	// ****************
	// Fetch engine
	// ****************
	tsico_fetch_t fst_q;
	logic [4:0] f_idx_q, s1_i_q, s2_i_q;
	logic [7:0] fch_q;
	logic [15:0] cw_q, s2_cw_q;
	logic s2_v_q;
	logic [7:0] dm_q;
	logic [NS-1:0][7:0] nxt_b_q;
	logic [NS-1:0] nxt_oe_q;

	wire [1:0] cw_mode = cw_q[CW_MODE_LSB +: 2];
	wire [1:0] s2_mode = s2_cw_q[CW_MODE_LSB +: 2];
	// Constant delay reads the bank completed last frame
	wire bank_sel = (cw_mode == MODE_CONST) ? !wbank_q : wbank_q;
	// Unused address bits are trusted to be zero
	wire [13:0] dm_a = {bank_sel, cw_q[CW_STR_LSB +: 5], cw_q[7:0]};
	wire [7:0] f_next = (g_ch == ch_last) ? 8'h00 : g_ch + 8'h01;

	always_ff @(posedge clk) begin
		if (s1_v_q) begin
			dm_q <= data_mem[dm_a];
		end
	end

	// Whole sweep takes NS+2 cycles and must end within one channel time
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			fst_q <= F_IDLE;
			f_idx_q <= 5'h00;
			fch_q <= 8'h00;
			cw_q <= 16'h0000;
			s1_v_q <= 1'b0;
			s1_i_q <= 5'h00;
			s2_v_q <= 1'b0;
			s2_i_q <= 5'h00;
			s2_cw_q <= 16'h0000;
			nxt_b_q <= '0;
			nxt_oe_q <= '0;
		end else begin
			s1_v_q <= fst_q == F_RUN;
			s1_i_q <= f_idx_q;
			s2_v_q <= s1_v_q;
			s2_i_q <= s1_i_q;
			s2_cw_q <= cw_q;
			unique case (fst_q)
				F_IDLE: begin
					if (g_chan) begin
						fst_q <= F_RUN;
						f_idx_q <= 5'h00;
						fch_q <= f_next;
					end
				end
				F_RUN: begin
					cw_q <= conn_mem[{f_idx_q, fch_q}];
					f_idx_q <= f_idx_q + 5'h01;
					if (f_idx_q == 5'(NS - 1)) begin
						fst_q <= F_IDLE;
					end
				end
				default: fst_q <= F_IDLE;
			endcase
			if (s2_v_q) begin
				nxt_b_q[s2_i_q] <= (s2_mode == MODE_PROC) ? s2_cw_q[7:0] : dm_q;
				nxt_oe_q[s2_i_q] <= s2_mode != MODE_HIZ;
			end
		end
	end

	// ****************
	// Transmitters
	// ****************
	for (genvar s = 0; s < NS; s++) begin : g_tx
		logic [7:0] sr_q;
		logic oe_q;

		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				sr_q <= 8'h00;
				oe_q <= 1'b0;
			end else if (g_chan) begin
				sr_q <= nxt_b_q[s];
				oe_q <= nxt_oe_q[s];
			end else if (g_bit) begin
				sr_q <= {sr_q[6:0], 1'b0};
			end else if (lk_edge && !g_in) begin
				oe_q <= 1'b0;
			end
		end

		assign tx_out[s] = sr_q[7];
		assign tx_oe[s] = oe_q;
	end

	// ****************
	// Frame evaluation
	// ****************
	tsico_eval_t est_q;
	logic [11:0] ecnt_q;
	logic ev_prev_q;

	wire ev_bit = rx_all[evsel_q];
	wire ev_fall = ev_prev_q && !ev_bit;
	wire [11:0] ecnt_nx = (lk_edge && ecnt_q != 12'hFFF) ? ecnt_q + 12'h001 : ecnt_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			est_q <= E_IDLE;
			ecnt_q <= 12'h000;
			ev_prev_q <= 1'b0;
			far_q <= FAR_RST;
		end else begin
			ev_prev_q <= ev_bit;
			unique case (est_q)
				E_IDLE: begin
					if (eval_start) begin
						est_q <= E_WAIT;
						far_q <= FAR_RST;
					end
				end
				E_WAIT: begin
					if (fstart) begin
						est_q <= E_COUNT;
						ecnt_q <= 12'h000;
					end
				end
				E_COUNT: begin
					ecnt_q <= ecnt_nx;
					// The edge that shows the fall is itself a counted half period
					if (ev_fall || ecnt_q == 12'hFFF) begin
						far_q <= (16'h0001 << FAR_DONE_BIT) | 16'(ecnt_nx);
						est_q <= E_IDLE;
					end
				end
				default: est_q <= E_IDLE;
			endcase
		end
	end
endmodule // tsico_top

// [testbench/tsico_asserts.sv]
// Register port checker of the slot-interchange block
`timescale 1ns/1ps
module tsico_asserts import tsico_pkg::*; #(
	parameter int NS = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [14:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Serial link
	input wire logic link_clk,
	input wire logic frame_pulse_in,
	input wire logic [NS-1:0] rx_in,
	input wire logic [NS-1:0] tx_out,
	input wire logic [NS-1:0] tx_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	wire is_ofs = reg_addr >= A_OFS0 && reg_addr <= A_OFS7;
	// ****
	// Properties
	// ****
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved");
	AST_CTRL_ZERO: assert property (reg_rd && reg_addr == A_CTRL |=> reg_rdata[15:5] == '0 && reg_rdata[3:2] == '0)
		else $error("control spare bits set");
	AST_RATE_RW: assert property (reg_wr && reg_addr == A_CTRL ##1 !reg_wr ##1 reg_rd && reg_addr == A_CTRL
		|=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3)) else $error("rate not kept");
	AST_OFS_RW: assert property (reg_wr && is_ofs ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("offset not kept");
	AST_CONN_RW: assert property (reg_wr && reg_addr[14] ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
		|=> {reg_rdata[15:14], reg_rdata[12:0]} == {$past(reg_wdata[15:14], 3), $past(reg_wdata[12:0], 3)})
		else $error("connection word not kept");
	AST_UNMAPPED: assert property (reg_rd && !reg_addr[14] && reg_addr > A_EVSEL |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	AST_EVSEL_ZERO: assert property (reg_rd && reg_addr == A_EVSEL |=> reg_rdata[15:5] == '0)
		else $error("select spare bits set");
	AST_FAR_ZERO: assert property (reg_rd && reg_addr == A_FAR |=> reg_rdata[14:12] == '0)
		else $error("alignment spare bits set");
	cover property (reg_wr && reg_addr == A_CTRL && reg_wdata[CTL_EVAL_BIT]);
	cover property (|tx_oe);
	cover property (reg_rd && reg_addr == A_FAR ##1 reg_rdata[FAR_DONE_BIT]);
endmodule // tsico_asserts
bind tsico_top tsico_asserts #(.NS(NS)) tsico_asserts_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
	.frame_pulse_in(frame_pulse_in), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe));

// [testbench/tsico_link_model.sv]
// Free-running TDM link source at the lowest rate
`timescale 1ns/1ps
module tsico_link_model #(
	parameter int NS = 32,
	parameter int FHP = 1024
) (
	// Stream delay in half periods
	input wire logic [3:0] dly,
	// Link side
	output logic link_clk,
	output logic frame_pulse_in,
	output logic [NS-1:0] rx_in,
	// Half-period count for the bench
	output int hp
);
	function automatic logic [7:0] byte_of(input int s, input int c);
		// Lone leading one in channel 0 makes the first fall easy to find
		if (c == 0) return 8'h80;
		// Quiet last channel, so an offset tail past the pulse shows no early fall
		if (c == FHP / 32 - 1) return 8'h00;
		return {c[3:0], s[2:0], 1'b0};
	endfunction
	initial begin
		int p;
		logic [7:0] b;
		link_clk = 1'b0;
		frame_pulse_in = 1'b0;
		rx_in = '0;
		hp = FHP - 1;
		#3;
		forever begin
			#62.5;
			link_clk = ~link_clk;
			hp = (hp + 1) % FHP;
			frame_pulse_in = hp < 2;
			p = (hp - int'(dly) + FHP) % FHP;
			for (int s = 0; s < NS; s++) begin
				b = byte_of(s, p / 32);
				rx_in[s] = b[7 - (p / 4) % 8];
			end
		end
	end
endmodule // tsico_link_model

// [testbench/tsico_top_test.sv]
// Self-checking bench of the slot-interchange block
`timescale 1ns/1ps
module tsico_top_test import tsico_pkg::*;;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [14:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic link_clk;
	logic frame_pulse_in;
	logic [31:0] rx_in;
	logic [31:0] tx_out;
	logic [31:0] tx_oe;
	logic [3:0] dly = 4'h0;
	logic [3:0] dlys [3] = '{4'h0, 4'h5, 4'hF};
	logic [15:0] rv;
	logic [7:0] tx_byte [4];
	logic [3:0] oe;
	int hp;
	int n_errors = 0;
	int num_checks = 0;
	int cycles = 0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		// Three trials of three frames each fit well below this
		if (cycles == 80000) begin
			n_errors++;
			results();
		end
	end
	tsico_top #(.NS(32)) tsico_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
		.frame_pulse_in(frame_pulse_in), .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe));
	tsico_link_model #(.NS(32), .FHP(1024)) tsico_link_model_inst (.dly(dly), .link_clk(link_clk),
		.frame_pulse_in(frame_pulse_in), .rx_in(rx_in), .hp(hp));
	// ****
	// Tasks
	// ****
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [14:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		// Data stand through the next cycle; take them at its closing edge
		@(posedge clk);
		rv = reg_rdata;
	endtask
	function automatic logic [14:0] conn(input int o);
		return {2'h2, 5'(o), 8'h05};
	endfunction
	task automatic next_frame();
		wait (hp == 1);
		wait (hp == 0);
	endtask
	// Sample mid-bit of output channel 5 on outputs 0 to 3
	task automatic grab();
		for (int i = 0; i < 8; i++) begin
			wait (hp == 162 + 4 * i);
			#20;
			if (i == 0) oe = tx_oe[3:0];
			for (int o = 0; o < 4; o++) tx_byte[o][7 - i] = tx_out[o];
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < NOFS; k++) begin
			rd(A_OFS0 + 15'(k));
			chk("offset reset", OFS_RST, rv);
		end
		rd(A_FAR);
		chk("alignment reset", FAR_RST, rv);
		wr(15'h0100, 16'hFFFF);
		rd(15'h0100);
		chk("unmapped", 16'h0000, rv);
		for (int k = 0; k < NOFS; k++) begin
			wr(A_OFS0 + 15'(k), 16'(16'h1111 * (k + 8)));
			rd(A_OFS0 + 15'(k));
			chk("offset", 16'(16'h1111 * (k + 8)), rv);
		end
		for (int r = 0; r < 4; r++) begin
			wr(A_CTRL, 16'(r));
			rd(A_CTRL);
			chk("rate", 16'(r), rv);
		end
		wr(A_EVSEL, 16'hFFE7);
		rd(A_EVSEL);
		chk("stream select", 16'h0007, rv);
		for (int k = 0; k < NOFS; k++) wr(A_OFS0 + 15'(k), OFS_RST);
		wr(A_CTRL, 16'h0000);
		wr(conn(0), {MODE_PROC, 6'h00, 8'hA5});
		wr(conn(1), {MODE_HIZ, 14'h0000});
		wr(conn(3), {MODE_CONST, 1'b0, 5'h07, 8'h02});
		wr(conn(2), {MODE_VAR, 1'b0, 5'h07, 8'h01});
		rd(conn(2));
		chk("connection word", {MODE_VAR, 1'b0, 5'h07, 8'h01}, rv);
		$display("register test done");
		foreach (dlys[t]) begin
			dly <= dlys[t];
			wr(A_OFS0 + 15'h0001, {dlys[t], 12'h000});
			wr(A_CTRL, 16'h0000);
			wr(A_CTRL, 16'h0010);
			next_frame();
			next_frame();
			grab();
			chk("processor byte", 16'h00A5, {8'h00, tx_byte[0]});
			chk("enables", 16'h000D, {12'h000, oe});
			chk("variable byte", 16'h001E, {8'h00, tx_byte[2]});
			chk("constant byte", 16'h002E, {8'h00, tx_byte[3]});
			rd(A_FAR);
			chk("alignment", {1'b1, 3'h0, 12'(dlys[t]) + 12'h004}, rv);
			$display("offset test done, delay %0d", dlys[t]);
		end
		results();
	end
endmodule // tsico_top_test
